// ==== ledsc_pkg.sv ====
`default_nettype none
package ledsc_pkg;
	// frame lengths and channel layout
	localparam int BRIGHT_LEN = 192;
	localparam int TRIM_LEN = 96;
	localparam int CHANS = 16;
	localparam int BRIGHT_W = 12;
	localparam int TRIM_W = 6;
	localparam int GROUPS = 4;
	localparam int GROUP_SIZE = 4;
	// status packet field positions
	localparam int SID_OPEN_LO = 16;
	localparam int SID_TRIM_LO = 72;
	localparam int SID_TOP_PAD = 24;
	localparam int SID_MID_PAD = 40;
	// values after reset, and the pwm count at which the counter holds
	localparam logic [11:0] BRIGHT_RESET = 12'hfff;
	localparam logic [5:0] TRIM_RESET = 6'h3f;
	localparam logic [12:0] PWM_FULL = 13'h1000;
	// timing
	localparam int SYS_CLK_NS = 50;
	localparam int OPEN_SAMPLE_NS = 1000;
	localparam int OPEN_SAMPLE_CYC = (OPEN_SAMPLE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam logic [5:0] OPEN_SAMPLE_AGE = 6'(OPEN_SAMPLE_CYC);
	localparam int STAGGER_NS = 25;
	localparam int STAGGER_CYC = (STAGGER_NS / SYS_CLK_NS) < 1 ? 1 : (STAGGER_NS / SYS_CLK_NS);
	// event buffer
	localparam int FIFO_DEPTH = 8;
	localparam int EVT_W = 3;

	// pins arriving from outside the clock domain
	typedef struct packed {
		logic shift_clock;
		logic serial_in;
		logic latch_strobe;
		logic mode_sel;
		logic output_blank;
		logic pwm_ref_clock;
		logic over_temp;
		logic stagger_off;
	} ledsc_pins_t;

	// one serial event: a bit or a latch, with the mode seen at that time
	typedef struct packed {
		logic is_latch;
		logic data;
		logic mode;
	} ledsc_evt_t;

	typedef enum logic [0:0] {
		LEDSC_ST_TAKE = 1'b0,
		LEDSC_ST_LOAD_SID = 1'b1
	} ledsc_state_t;
endpackage
`default_nettype wire

// ==== ledsc_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module ledsc_fifo #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [DEPTH-1:0][WIDTH-1:0] mem;
	logic [DEPTH-1:0][WIDTH-1:0] next_mem;
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
		ptr_step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// pointer and storage update
	always_comb
	begin
		next_mem = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push)
		begin
			next_mem[wr_ptr] = in_data;
			next_wr_ptr = ptr_step(wr_ptr);
		end
		if (pop)
			next_rd_ptr = ptr_step(rd_ptr);
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			mem <= '0;
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			mem <= next_mem;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	default clocking fifo_cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	chk_fifo_full_holds: assert property (!in_ready && !pop |=> !in_ready && $stable(wr_ptr))
		else $error("fifo took a word while full");
	chk_fifo_count_track: assert property (push && !pop |=> count == $past(count) + 1'b1)
		else $error("fifo count did not follow a push");
endmodule
`default_nettype wire

// ==== ledsc_top.sv ====
// Overview of operation
// - each shift clock rising edge moves serial_in into the input shift register.
// - after a full frame, latch_strobe rising edge commits shift register to data registers.
// - serial_out carries shifted-through data for chaining devices.
// - mode 0 gives a 192-bit register, mode 1 a 96-bit register.
// - latch updates brightness_value in mode 0, current_trim in mode 1.
// - after reset the block runs in mode 0 with shift register cleared.
// - open LED or overtemperature turns on the fault_flag_low pull-down.
// - with no fault the fault_flag_low pull-down stays off.
// - open LED flagged only while detection active and channel voltage below threshold.
// - each channel voltage is sampled one microsecond after switch-on.
// - open LED flags are readable in the status_readback_packet during brightness loading.
// - output_blank high switches all sixteen sink channels off.
// - output_blank high also clears the PWM counter.
// - output_blank low lets channels run under PWM of brightness_value; current_trim only feeds the status read-back.
// - channels switch in four groups of four, staggered, stagger removable.
// - after a brightness latch the shift register is reloaded with status data.
// - status bits 31:16 hold open flags, bits 167:72 current_trim.
// - reset sets each current_trim to 63 and brightness_value to 4095.
`timescale 1ns/10ps
`default_nettype none
module ledsc_top #(
	parameter int DEPTH = ledsc_pkg::FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire ledsc_pkg::ledsc_pins_t pins,
	input wire logic [15:0] sense_low,
	output logic serial_out,
	output logic fault_flag_low_o,
	output logic fault_flag_low_oe_n,
	output logic [15:0] sink_on,
	output logic active_mode
);
	localparam int DL_LEN = (ledsc_pkg::GROUPS - 1) * ledsc_pkg::STAGGER_CYC;
	// two-stage synchronisers plus one stage for edge finding
	ledsc_pkg::ledsc_pins_t pin_meta;
	ledsc_pkg::ledsc_pins_t pin_s;
	ledsc_pkg::ledsc_pins_t pin_d;
	logic [15:0] sense_meta;
	logic [15:0] sense_s;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			pin_meta <= '0;
			pin_s <= '0;
			pin_d <= '0;
			sense_meta <= '0;
			sense_s <= '0;
		end
		else
		begin
			pin_meta <= pins;
			pin_s <= pin_meta;
			pin_d <= pin_s;
			sense_meta <= sense_low;
			sense_s <= sense_meta;
		end
	end

	logic shift_rise;
	logic latch_rise;
	logic pwm_rise;
	assign shift_rise = pin_s.shift_clock & ~pin_d.shift_clock;
	assign latch_rise = pin_s.latch_strobe & ~pin_d.latch_strobe;
	assign pwm_rise = pin_s.pwm_ref_clock & ~pin_d.pwm_ref_clock;

	// event capture, held until the buffer accepts it
	ledsc_pkg::ledsc_evt_t evt_hold;
	ledsc_pkg::ledsc_evt_t next_evt_hold;
	logic hold_valid;
	logic next_hold_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	ledsc_pkg::ledsc_evt_t fifo_out;
	always_comb
	begin
		next_evt_hold = evt_hold;
		next_hold_valid = hold_valid & ~fifo_in_ready;
		if (shift_rise)
		begin
			next_evt_hold = '{is_latch: 1'b0, data: pin_s.serial_in, mode: pin_s.mode_sel};
			next_hold_valid = 1'b1;
		end
		else if (latch_rise)
		begin
			next_evt_hold = '{is_latch: 1'b1, data: 1'b0, mode: pin_s.mode_sel};
			next_hold_valid = 1'b1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			evt_hold <= '0;
			hold_valid <= 1'b0;
		end
		else
		begin
			evt_hold <= next_evt_hold;
			hold_valid <= next_hold_valid;
		end
	end

	ledsc_fifo #(.WIDTH(ledsc_pkg::EVT_W), .DEPTH(DEPTH)) u_evt_fifo (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.in_valid(hold_valid),
		.in_ready(fifo_in_ready),
		.in_data(evt_hold),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out)
	);

	// shift engine, data registers and status reload
	ledsc_pkg::ledsc_state_t state;
	ledsc_pkg::ledsc_state_t next_state;
	logic [ledsc_pkg::BRIGHT_LEN-1:0] sreg;
	logic [ledsc_pkg::BRIGHT_LEN-1:0] next_sreg;
	logic [15:0][11:0] bright;
	logic [15:0][11:0] next_bright;
	logic [15:0][5:0] trim;
	logic [15:0][5:0] next_trim;
	logic [15:0] open_flag;
	logic evt_take;
	function automatic logic [ledsc_pkg::BRIGHT_LEN-1:0] sid_pack(input logic [15:0][5:0] t, input logic [15:0] o);
		sid_pack = {{ledsc_pkg::SID_TOP_PAD{1'b0}}, t, {ledsc_pkg::SID_MID_PAD{1'b0}}, o, 16'h0000};
	endfunction
	assign fifo_out_ready = (state == ledsc_pkg::LEDSC_ST_TAKE);
	assign evt_take = fifo_out_valid & fifo_out_ready;
	always_comb
	begin
		next_state = state;
		next_sreg = sreg;
		next_bright = bright;
		next_trim = trim;
		unique case (state)
			ledsc_pkg::LEDSC_ST_TAKE:
			begin
				if (evt_take && !fifo_out.is_latch)
					next_sreg = {sreg[ledsc_pkg::BRIGHT_LEN-2:0], fifo_out.data};
				else if (evt_take && !fifo_out.mode)
				begin
					next_bright = sreg;
					next_state = ledsc_pkg::LEDSC_ST_LOAD_SID;
				end
				else if (evt_take)
					next_trim = sreg[ledsc_pkg::TRIM_LEN-1:0];
			end
			ledsc_pkg::LEDSC_ST_LOAD_SID:
			begin
				next_sreg = sid_pack(trim, open_flag);
				next_state = ledsc_pkg::LEDSC_ST_TAKE;
			end
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			state <= ledsc_pkg::LEDSC_ST_TAKE;
			sreg <= '0;
			bright <= {ledsc_pkg::CHANS{ledsc_pkg::BRIGHT_RESET}};
			trim <= {ledsc_pkg::CHANS{ledsc_pkg::TRIM_RESET}};
		end
		else
		begin
			state <= next_state;
			sreg <= next_sreg;
			bright <= next_bright;
			trim <= next_trim;
		end
	end

	// serial output tap at the far end of the active length
	logic next_serial_out;
	logic next_active_mode;
	always_comb
	begin
		next_active_mode = pin_s.mode_sel;
		next_serial_out = active_mode ? sreg[ledsc_pkg::TRIM_LEN-1] : sreg[ledsc_pkg::BRIGHT_LEN-1];
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			active_mode <= 1'b0;
			serial_out <= 1'b0;
		end
		else
		begin
			active_mode <= next_active_mode;
			serial_out <= next_serial_out;
		end
	end

	// pwm counter, channel compare and group stagger
	logic [12:0] pwm_cnt;
	logic [12:0] next_pwm_cnt;
	logic [15:0] on_raw;
	logic [DL_LEN:0][15:0] dl;
	logic [DL_LEN:0][15:0] next_dl;
	logic [15:0] next_sink_on;
	always_comb
	begin
		next_pwm_cnt = pwm_cnt;
		if (pin_s.output_blank)
			next_pwm_cnt = '0;
		else if (pwm_rise && pwm_cnt != ledsc_pkg::PWM_FULL)
			next_pwm_cnt = pwm_cnt + 13'h0001;
		for (int n = 0; n < ledsc_pkg::CHANS; n++)
			on_raw[n] = (pwm_cnt != '0) && ({1'b0, bright[n]} >= pwm_cnt);
		next_dl = {dl[DL_LEN-1:0], on_raw};
		for (int g = 0; g < ledsc_pkg::GROUPS; g++)
		begin
			for (int k = 0; k < ledsc_pkg::GROUP_SIZE; k++)
			begin
				if (pin_s.output_blank)
					next_sink_on[g*ledsc_pkg::GROUP_SIZE+k] = 1'b0;
				else if (pin_s.stagger_off)
					next_sink_on[g*ledsc_pkg::GROUP_SIZE+k] = dl[0][g*ledsc_pkg::GROUP_SIZE+k];
				else
					next_sink_on[g*ledsc_pkg::GROUP_SIZE+k] =
						dl[g*ledsc_pkg::STAGGER_CYC][g*ledsc_pkg::GROUP_SIZE+k];
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			pwm_cnt <= '0;
			dl <= '0;
			sink_on <= '0;
		end
		else
		begin
			pwm_cnt <= next_pwm_cnt;
			dl <= next_dl;
			sink_on <= next_sink_on;
		end
	end

	// open detection: sample each channel a fixed time after switch-on
	logic [15:0][5:0] on_age;
	logic [15:0][5:0] next_on_age;
	logic [15:0] next_open_flag;
	logic detect_active;
	logic next_fault_oe_n;
	assign detect_active = pin_s.latch_strobe & ~pin_s.output_blank;
	always_comb
	begin
		next_on_age = on_age;
		next_open_flag = open_flag;
		for (int n = 0; n < ledsc_pkg::CHANS; n++)
		begin
			if (!sink_on[n])
				next_on_age[n] = '0;
			else if (on_age[n] <= ledsc_pkg::OPEN_SAMPLE_AGE)
				next_on_age[n] = on_age[n] + 6'h01;
			if (on_age[n] == ledsc_pkg::OPEN_SAMPLE_AGE)
				next_open_flag[n] = detect_active & sense_s[n];
		end
		next_fault_oe_n = ~((|open_flag) | pin_s.over_temp);
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			on_age <= '0;
			open_flag <= '0;
			fault_flag_low_o <= 1'b0;
			fault_flag_low_oe_n <= 1'b1;
		end
		else
		begin
			on_age <= next_on_age;
			open_flag <= next_open_flag;
			fault_flag_low_o <= 1'b0;
			fault_flag_low_oe_n <= next_fault_oe_n;
		end
	end

	default clocking top_cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	sequence bright_latch_taken;
		evt_take && fifo_out.is_latch && !fifo_out.mode;
	endsequence
	sequence sid_loaded;
		state == ledsc_pkg::LEDSC_ST_LOAD_SID ##1 sreg == sid_pack($past(trim), $past(open_flag));
	endsequence
	sequence quiet_staggered;
		(!pin_s.output_blank && !pin_s.stagger_off)[*2];
	endsequence
	chk_bit_reaches_sreg: assert property (shift_rise && !hold_valid && !fifo_out_valid && fifo_out_ready
		|-> ##3 sreg[0] == $past(pin_s.serial_in, 3))
		else $error("sampled bit did not reach the shift register");
	chk_bright_latch: assert property (bright_latch_taken |=> bright == $past(sreg) && $stable(trim))
		else $error("brightness latch wrong");
	chk_trim_latch: assert property (evt_take && fifo_out.is_latch && fifo_out.mode
		|=> trim == $past(sreg[ledsc_pkg::TRIM_LEN-1:0]) && $stable(bright) && state == ledsc_pkg::LEDSC_ST_TAKE)
		else $error("trim latch wrong");
	chk_sid_reload: assert property (bright_latch_taken |=> sid_loaded)
		else $error("status packet not loaded after brightness latch");
	chk_serial_tap: assert property (##1 serial_out ==
		$past(active_mode ? sreg[ledsc_pkg::TRIM_LEN-1] : sreg[ledsc_pkg::BRIGHT_LEN-1]))
		else $error("serial out does not follow the active tap");
	chk_fault_drive: assert property (##1 fault_flag_low_oe_n == !$past((|open_flag) | pin_s.over_temp))
		else $error("fault pull-down mismatch");
	chk_blank_clears: assert property (pin_s.output_blank |=> sink_on == '0 && pwm_cnt == '0)
		else $error("blank did not clear outputs and counter");
	chk_open_needs_detect: assert property ($rose(open_flag[5]) |-> $past(detect_active) && $past(sense_s[5]))
		else $error("open flag set without detection");
	chk_open_sample_age: assert property (on_age[0] == ledsc_pkg::OPEN_SAMPLE_AGE
		|-> $past(sink_on[0], ledsc_pkg::OPEN_SAMPLE_CYC) && sink_on[0])
		else $error("open sample not a full delay after switch-on");
	chk_group_stagger: assert property (quiet_staggered |=> sink_on[7:4] == $past(dl[0][7:4], 2)
		&& sink_on[3:0] == $past(dl[0][3:0]) && sink_on[15:12] == $past(dl[0][15:12], 4))
		else $error("group stagger wrong");
	chk_reset_values: assert property ($past(sys_rst) |-> bright[0] == ledsc_pkg::BRIGHT_RESET
		&& trim[15] == ledsc_pkg::TRIM_RESET && !active_mode && sreg == '0)
		else $error("reset values wrong");
endmodule
`default_nettype wire

// ==== ledsc_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// host side of the serial link; shift clock idles low between frames
module ledsc_host (
	input wire logic sys_clk,
	input wire logic serial_out,
	output logic shift_clock,
	output logic serial_in,
	output logic latch_strobe
);
	// idle levels
	initial
	begin
		shift_clock = 1'h0;
		serial_in = 1'h0;
		latch_strobe = 1'h0;
	end

	// shift n bits msb first, grab serial_out just before each rising edge
	task automatic send(input logic [191:0] v, input int n, output logic [191:0] cap);
		cap = '0;
		for (int i = n - 1; i >= 0; i--)
		begin
			@(negedge sys_clk) serial_in = v[i];
			repeat (2) @(negedge sys_clk);
			cap[i] = serial_out;
			shift_clock = 1'h1;
			repeat (4) @(negedge sys_clk);
			shift_clock = 1'h0;
			@(negedge sys_clk) serial_in = ~v[i]; // inverted data after hold
		end
	endtask

	// latch strobe level, only after the frame has settled
	task automatic latch(input logic lvl);
		repeat (4) @(negedge sys_clk);
		latch_strobe = lvl;
	endtask
endmodule
`default_nettype wire

// ==== led_driver_serial_control_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module led_driver_serial_control_test;
	logic sys_clk;
	logic sys_rst;
	logic mode_sel, output_blank, pwm_ref_clock, over_temp, stagger_off;
	logic shift_clock, serial_in, latch_strobe;
	logic [15:0] sense_low;
	logic serial_out, ff_o, ff_oe_n, active_mode;
	logic [15:0] sink_on;
	logic fault_line;
	ledsc_pkg::ledsc_pins_t pins;
	int fail_count;
	int compares;
	logic [191:0] cap;
	logic [191:0] bright;
	logic [95:0] trim;
	int row_pulses [7] = '{1, 4, 10, 1, 0, 1, 2};
	logic row_blank [7] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0};
	logic row_stg [7] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
	logic [15:0] row_sink [7] = '{16'hfffe, 16'hffe0, 16'h8000, 16'h0000, 16'h0000, 16'hfffe, 16'hfff8};

	// pin bundle and the pulled-up fault line
	assign pins = {shift_clock, serial_in, latch_strobe, mode_sel, output_blank, pwm_ref_clock, over_temp, stagger_off};
	assign fault_line = ff_oe_n ? 1'h1 : ff_o;

	ledsc_top #(.DEPTH(ledsc_pkg::FIFO_DEPTH)) dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .pins(pins), .sense_low(sense_low),
		.serial_out(serial_out), .fault_flag_low_o(ff_o), .fault_flag_low_oe_n(ff_oe_n),
		.sink_on(sink_on), .active_mode(active_mode)
	);

	ledsc_host host (
		.sys_clk(sys_clk), .serial_out(serial_out), .shift_clock(shift_clock),
		.serial_in(serial_in), .latch_strobe(latch_strobe)
	);

	// clock
	initial
	begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic chk(input string name, input logic [191:0] seen, input logic [191:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		if (fail_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// n pulses of the pwm reference, 2 cycles high and 2 low
	task automatic pulse(input int n);
		for (int i = 0; i < n; i++)
		begin
			pwm_ref_clock = 1'h1;
			wt(2);
			pwm_ref_clock = 1'h0;
			wt(2);
		end
	endtask

	// watchdog, a few times the expected run length
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		summarize();
	end

	// main sequence
	initial
	begin
		sys_rst = 1'h1;
		mode_sel = 1'h0;
		output_blank = 1'h1;
		pwm_ref_clock = 1'h0;
		over_temp = 1'h0;
		stagger_off = 1'h0;
		sense_low = 16'h0000;
		fail_count = 0;
		compares = 0;
		trim = 96'h0123_4567_89ab_cdef_1357_9bdf;
		for (int n = 0; n < 16; n++)
			bright[n * 12 +: 12] = 12'(n);
		wt(5);
		sys_rst = 1'h0;
		wt(3);
		chk("serial_out", serial_out, 1'h0);
		chk("active_mode", active_mode, 1'h0);
		chk("sink_on", sink_on, 16'h0000);
		chk("fault_line", fault_line, 1'h1);
		// full-scale default brightness, sense low without detection
		sense_low = 16'hffff;
		output_blank = 1'h0;
		wt(3);
		pulse(1);
		wt(30);
		chk("sink_on", sink_on, 16'hffff);
		chk("fault_line", fault_line, 1'h1);
		output_blank = 1'h1;
		sense_low = 16'h0000;
		wt(4);
		chk("sink_on", sink_on, 16'h0000);
		// overtemperature pulls the line low
		over_temp = 1'h1;
		wt(6);
		chk("fault_line", fault_line, 1'h0);
		chk("ff_o", ff_o, 1'h0);
		over_temp = 1'h0;
		wt(6);
		chk("fault_line", fault_line, 1'h1);
		// trim frame twice; second pass shows the first at the far end
		mode_sel = 1'h1;
		wt(4);
		chk("active_mode", active_mode, 1'h1);
		host.send({96'h0, trim}, 96, cap);
		host.send({96'h0, trim}, 96, cap);
		chk("chain", cap[95:0], trim);
		host.latch(1'h1);
		host.latch(1'h0);
		// brightness frame, latch held high for detection on channel 5
		mode_sel = 1'h0;
		wt(4);
		host.send(bright, 192, cap);
		sense_low = 16'h0020;
		host.latch(1'h1);
		output_blank = 1'h0;
		wt(3);
		pulse(1);
		wt(30);
		chk("open_fault", fault_line, 1'h0);
		host.latch(1'h0);
		output_blank = 1'h1;
		sense_low = 16'h0000;
		wt(4);
		// status read-back after the brightness latch, reloading the same frame
		host.send(bright, 192, cap);
		chk("sid_trim", cap[167:72], trim);
		chk("sid_open", cap[31:16], 16'h0000);
		chk("sid_rsvd", {cap[191:168], cap[71:32], cap[15:0]}, 80'h0);
		// second latch packs the open flag found on channel 5
		host.latch(1'h1);
		host.latch(1'h0);
		host.send(192'h0, 192, cap);
		chk("sid_open", cap[31:16], 16'h0020);
		chk("sid_trim", cap[167:72], trim);
		// pwm rows on brightness n for channel n
		for (int r = 0; r < 7; r++)
		begin
			output_blank = row_blank[r];
			stagger_off = row_stg[r];
			wt(3);
			pulse(row_pulses[r]);
			wt(8);
			chk("pwm_row", sink_on, row_sink[r]);
		end
		// mid-run reset brings back full-scale brightness
		output_blank = 1'h1;
		sys_rst = 1'h1;
		wt(5);
		sys_rst = 1'h0;
		wt(3);
		chk("serial_out", serial_out, 1'h0);
		chk("sink_on", sink_on, 16'h0000);
		chk("fault_line", fault_line, 1'h1);
		output_blank = 1'h0;
		wt(3);
		pulse(1);
		wt(8);
		chk("sink_on", sink_on, 16'hffff);
		summarize();
	end
endmodule
`default_nettype wire
